/* src/boot_pkg.sv */
// constants and types for the serial flash loader command interpreter
// assumes one 100 MHz clock; flash array and serial pins live outside
package boot_pkg;
    localparam int          CLK_HZ          = 100_000_000;
    localparam logic [7:0]  OP_SET_VARS     = 8'h01;
    localparam logic [7:0]  OP_READ         = 8'h02;
    localparam logic [7:0]  OP_WRITE        = 8'h03;
    localparam logic [7:0]  OP_ECHO_A       = 8'hFF;
    localparam logic [7:0]  OP_ECHO_B       = 8'hFA;
    localparam logic [7:0]  ACK_BYTE        = 8'h02;
    localparam logic [15:0] PROGRAM_SELECT_N_TIME_RESET = 16'h1770;
    // rate code reset value, the 115200 entry
    localparam logic [23:0] RATE_CODE_RESET = 24'h00001A;
    // wide enough for the slowest table entry, 333333 cycles at 300
    localparam int          BIT_W           = 19;

    // cycles per bit for a table entry; unknown codes keep 115200
    function automatic logic [BIT_W-1:0] bit_cycles(input logic [23:0] code);
        int unsigned baud;
        baud = 115200;
        unique case (code)
            24'h002710: baud = 300;
            24'h001388: baud = 600;
            24'h0009C4: baud = 1200;
            24'h0004E2: baud = 2400;
            24'h000271: baud = 4800;
            24'h004138: baud = 9600;
            24'h00809C: baud = 19200;
            24'h00C04E: baud = 38400;
            24'h00C034: baud = 57600;
            24'h00001A: baud = 115200;
            24'h00000D: baud = 230400;
            24'h004006: baud = 460800;
            24'h008003: baud = 921600;
            24'h000003: baud = 1000000;
            24'h000002: baud = 1500000;
            24'h000001: baud = 2000000;
            24'h000000: baud = 3000000;
            default:    baud = 115200;
        endcase
        bit_cycles = BIT_W'(CLK_HZ / baud);
    endfunction

    typedef enum logic [3:0] {
        ST_OPCODE   = 4'b0000,
        ST_ARGS     = 4'b0001,
        ST_ACK      = 4'b0010,
        ST_RD_FETCH = 4'b0011,
        ST_RD_SEND  = 4'b0100,
        ST_WR_DATA  = 4'b0101,
        ST_WR_FLASH = 4'b0110,
        ST_ECHO     = 4'b0111,
        ST_RATE     = 4'b1000,
        ST_IDLE_RUN = 4'b1001
    } boot_state_t;
endpackage

/* src/serial_port.sv */
// 8n1 serial transmitter and receiver with rts/cts
// assumes bit time given in clk cycles, steady while a byte moves
`timescale 1ns/1ps
module serial_port #(
    parameter int BIT_W = 16
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // bit time
    input  wire logic [BIT_W-1:0] bit_cycles,
    // serial pins
    input  wire logic             rxd,
    output logic                  txd,
    input  wire logic             cts_n,
    output logic                  rts_n,
    // byte side
    output logic [7:0]            rx_data,
    output logic                  rx_valid,
    input  wire logic             rx_ready,
    input  wire logic [7:0]       tx_data,
    input  wire logic             tx_valid,
    output logic                  tx_ready
);
    initial begin
        if (BIT_W < 8) $error("BIT_W too small");
    end

    logic [2:0]       rx_sync_reg;
    logic [2:0]       cts_sync_reg;
    logic             rx_lvl_reg;
    logic             cts_lvl_reg;
    logic [BIT_W-1:0] rx_cnt_reg;
    logic [3:0]       rx_bit_reg;
    logic [7:0]       rx_sh_reg;
    logic             rx_busy_reg;
    logic             rx_full_reg;
    logic [7:0]       rx_data_reg;
    logic [BIT_W-1:0] tx_cnt_reg;
    logic [3:0]       tx_bit_reg;
    logic [9:0]       tx_sh_reg;
    logic             tx_busy_reg;

    // three stages; level changes when second and third agree
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_sync_reg  <= 3'h7;
            cts_sync_reg <= 3'h7;
            rx_lvl_reg   <= 1'b1;
            cts_lvl_reg  <= 1'b1;
        end else begin
            rx_sync_reg  <= {rx_sync_reg[1:0], rxd};
            cts_sync_reg <= {cts_sync_reg[1:0], cts_n};
            if (rx_sync_reg[1] == rx_sync_reg[2]) rx_lvl_reg <= rx_sync_reg[2];
            if (cts_sync_reg[1] == cts_sync_reg[2]) cts_lvl_reg <= cts_sync_reg[2];
        end
    end

    // receiver samples mid bit
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_cnt_reg  <= '0;
            rx_bit_reg  <= 4'h0;
            rx_sh_reg   <= 8'h00;
            rx_busy_reg <= 1'b0;
            rx_full_reg <= 1'b0;
            rx_data_reg <= 8'h00;
        end else begin
            if (rx_full_reg && rx_ready) rx_full_reg <= 1'b0;
            if (!rx_busy_reg) begin
                if (!rx_lvl_reg) begin
                    rx_busy_reg <= 1'b1;
                    rx_bit_reg  <= 4'h0;
                    rx_cnt_reg  <= bit_cycles >> 1;
                end
            end else if (rx_cnt_reg != '0) begin
                rx_cnt_reg <= rx_cnt_reg - 1'b1;
            end else begin
                rx_cnt_reg <= bit_cycles - 1'b1;
                rx_bit_reg <= rx_bit_reg + 4'h1;
                if (rx_bit_reg == 4'h0 && rx_lvl_reg) begin
                    rx_busy_reg <= 1'b0;
                end else if (rx_bit_reg == 4'h9) begin
                    rx_busy_reg <= 1'b0;
                    // framing error drops the byte
                    if (rx_lvl_reg) begin
                        rx_full_reg <= 1'b1;
                        rx_data_reg <= rx_sh_reg;
                    end
                end else if (rx_bit_reg != 4'h0) begin
                    rx_sh_reg <= {rx_lvl_reg, rx_sh_reg[7:1]};
                end
            end
        end
    end

    // transmitter holds start while far end deasserts cts
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_cnt_reg  <= '0;
            tx_bit_reg  <= 4'h0;
            tx_sh_reg   <= 10'h3FF;
            tx_busy_reg <= 1'b0;
        end else if (!tx_busy_reg) begin
            if (tx_valid && !cts_lvl_reg) begin
                tx_busy_reg <= 1'b1;
                tx_sh_reg   <= {1'b1, tx_data, 1'b0};
                tx_cnt_reg  <= bit_cycles - 1'b1;
                tx_bit_reg  <= 4'h0;
            end
        end else if (tx_cnt_reg != '0) begin
            tx_cnt_reg <= tx_cnt_reg - 1'b1;
        end else begin
            tx_cnt_reg <= bit_cycles - 1'b1;
            tx_sh_reg  <= {1'b1, tx_sh_reg[9:1]};
            tx_bit_reg <= tx_bit_reg + 4'h1;
            if (tx_bit_reg == 4'h9) tx_busy_reg <= 1'b0;
        end
    end

    // rts drops ready only while a byte waits unread
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) rts_n <= 1'b1;
        else          rts_n <= rx_full_reg;
    end

    assign txd      = tx_sh_reg[0];
    assign tx_ready = !tx_busy_reg && !cts_lvl_reg;
    assign rx_valid = rx_full_reg;
    assign rx_data  = rx_data_reg;
endmodule

/* src/boot_loader.sv */
// command interpreter for the serial flash loader
// assumes a flash port with one-cycle read latency and write done handshake
`timescale 1ns/1ps
module boot_loader
    import boot_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        reset_n,
    // mode strap
    input  wire logic                        program_select_n,
    output logic                             loader_active,
    // serial link
    input  wire logic                        rxd,
    output logic                             txd,
    input  wire logic                        cts_n,
    output logic                             rts_n,
    // flash port
    output logic [ADDR_W-1:0]                flash_addr,
    output logic                             flash_rd,
    input  wire logic [7:0]                  flash_rdata,
    output logic                             flash_wr,
    output logic [7:0]                       flash_wdata,
    input  wire logic                        flash_wr_done,
    // settings out
    output logic [15:0]                      program_time,
    output logic [23:0]                      rate_code
);
    import boot_pkg::*;

    initial begin
        if (ADDR_W != 16) $error("ADDR_W must be 16");
    end

    boot_state_t      state_reg;
    boot_state_t      after_ack_reg;
    logic [2:0]       strap_sync_reg;
    logic             strap_done_reg;
    logic [1:0]       strap_fill_reg;
    logic [7:0]       opcode_reg;
    logic [2:0]       arg_idx_reg;
    logic [7:0]       arg_reg [0:4];
    logic [7:0]       count_reg;
    logic [15:0]      addr_reg;
    logic [7:0]       tx_byte_reg;
    logic [BIT_W-1:0] bit_cycles_reg;
    logic [15:0]      program_time_reg;
    logic [23:0]      rate_code_reg;
    logic [7:0]       rx_data;
    logic             rx_valid;
    logic             rx_ready;
    logic             tx_valid;
    logic             tx_ready;
    logic             rd_pending_reg;
    logic             wr_pending_reg;
    logic [2:0]       arg_need;

    serial_port #(.BIT_W(BIT_W)) port_u (
        .clk        (clk),
        .reset_n    (reset_n),
        .bit_cycles (bit_cycles_reg),
        .rxd        (rxd),
        .txd        (txd),
        .cts_n      (cts_n),
        .rts_n      (rts_n),
        .rx_data    (rx_data),
        .rx_valid   (rx_valid),
        .rx_ready   (rx_ready),
        .tx_data    (tx_byte_reg),
        .tx_valid   (tx_valid),
        .tx_ready   (tx_ready)
    );

    // strap caught only once the pin has reached the third stage,
    // so the reset fill of the synchroniser is never taken as the mode
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_sync_reg <= 3'h7;
            strap_fill_reg <= 2'h0;
            strap_done_reg <= 1'b0;
            loader_active  <= 1'b0;
        end else begin
            strap_sync_reg <= {strap_sync_reg[1:0], program_select_n};
            if (strap_fill_reg != 2'h3) begin
                strap_fill_reg <= strap_fill_reg + 2'h1;
            end else if (!strap_done_reg && strap_sync_reg[1] == strap_sync_reg[2]) begin
                strap_done_reg <= 1'b1;
                loader_active  <= !strap_sync_reg[2];
            end
        end
    end

    assign arg_need = (opcode_reg == OP_SET_VARS) ? 3'd5 : 3'd3;
    assign rx_ready = loader_active && (state_reg == ST_OPCODE || state_reg == ST_ARGS ||
                      state_reg == ST_WR_DATA) && !wr_pending_reg;
    assign tx_valid = state_reg == ST_ACK || state_reg == ST_ECHO ||
                      (state_reg == ST_RD_SEND && !rd_pending_reg);

    // command sequencer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg      <= ST_IDLE_RUN;
            after_ack_reg  <= ST_OPCODE;
            opcode_reg     <= 8'h00;
            arg_idx_reg    <= 3'h0;
            count_reg      <= 8'h00;
            addr_reg       <= 16'h0000;
            tx_byte_reg    <= 8'h00;
            rd_pending_reg <= 1'b0;
            wr_pending_reg <= 1'b0;
            flash_rd       <= 1'b0;
            flash_wr       <= 1'b0;
            flash_wdata    <= 8'h00;
            for (int i = 0; i < 5; i++) arg_reg[i] <= 8'h00;
        end else begin
            flash_rd <= 1'b0;
            flash_wr <= 1'b0;
            unique case (state_reg)
                // run mode: loader stays inactive
                ST_IDLE_RUN: begin
                    if (loader_active) state_reg <= ST_OPCODE;
                end
                ST_OPCODE: begin
                    if (rx_valid) begin
                        opcode_reg  <= rx_data;
                        arg_idx_reg <= 3'h0;
                        if (rx_data == OP_ECHO_A || rx_data == OP_ECHO_B) begin
                            tx_byte_reg <= rx_data;
                            state_reg   <= ST_ECHO;
                        end else if (rx_data == OP_SET_VARS || rx_data == OP_READ ||
                                     rx_data == OP_WRITE) begin
                            state_reg <= ST_ARGS;
                        end
                        // unknown opcodes are dropped so sync can recover
                    end
                end
                ST_ARGS: begin
                    if (rx_valid) begin
                        arg_reg[arg_idx_reg] <= rx_data;
                        arg_idx_reg          <= arg_idx_reg + 3'h1;
                        if (arg_idx_reg == arg_need - 3'h1) begin
                            tx_byte_reg <= ACK_BYTE;
                            state_reg   <= ST_ACK;
                            addr_reg    <= {arg_reg[1], arg_reg[0]};
                            count_reg   <= rx_data;
                            if (opcode_reg == OP_WRITE) begin
                                addr_reg      <= {arg_reg[1], arg_reg[0]};
                                after_ack_reg <= (rx_data == 8'h00) ? ST_ACK : ST_WR_DATA;
                            end else if (opcode_reg == OP_READ) begin
                                after_ack_reg <= ST_RD_FETCH;
                            end else begin
                                after_ack_reg <= ST_RATE;
                            end
                        end
                    end
                end
                ST_ACK: begin
                    if (tx_ready) begin
                        state_reg     <= after_ack_reg;
                        after_ack_reg <= ST_OPCODE;
                    end
                end
                // wait for the ack stop bit; a held cts stalls the switch too
                ST_RATE: begin
                    if (tx_ready) state_reg <= ST_OPCODE;
                end
                ST_ECHO: begin
                    if (tx_ready) state_reg <= ST_OPCODE;
                end
                ST_RD_FETCH: begin
                    if (count_reg == 8'h00) begin
                        state_reg <= ST_OPCODE;
                    end else begin
                        flash_rd       <= 1'b1;
                        rd_pending_reg <= 1'b1;
                        state_reg      <= ST_RD_SEND;
                    end
                end
                ST_RD_SEND: begin
                    if (rd_pending_reg) begin
                        if (!flash_rd) begin
                            tx_byte_reg    <= flash_rdata;
                            rd_pending_reg <= 1'b0;
                        end
                    end else if (tx_ready) begin
                        addr_reg  <= addr_reg + 16'h0001;
                        count_reg <= count_reg - 8'h01;
                        state_reg <= ST_RD_FETCH;
                    end
                end
                ST_WR_DATA: begin
                    if (rx_valid && !wr_pending_reg) begin
                        flash_wdata    <= rx_data;
                        flash_wr       <= 1'b1;
                        wr_pending_reg <= 1'b1;
                        state_reg      <= ST_WR_FLASH;
                    end
                end
                // the next byte waits unread while each byte programs; rts holds the host only once it waits
                ST_WR_FLASH: begin
                    if (flash_wr_done) begin
                        wr_pending_reg <= 1'b0;
                        addr_reg       <= addr_reg + 16'h0001;
                        count_reg      <= count_reg - 8'h01;
                        if (count_reg == 8'h01) begin
                            tx_byte_reg <= ACK_BYTE;
                            state_reg   <= ST_ACK;
                        end else begin
                            state_reg <= ST_WR_DATA;
                        end
                    end
                end
                default: state_reg <= ST_OPCODE;
            endcase
        end
    end

    // settings apply once the ack has left, so the ack goes at the old rate
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            program_time_reg <= PROGRAM_SELECT_N_TIME_RESET;
            rate_code_reg    <= RATE_CODE_RESET;
            bit_cycles_reg   <= bit_cycles(RATE_CODE_RESET);
        end else if (state_reg == ST_RATE && tx_ready) begin
            program_time_reg <= {arg_reg[1], arg_reg[0]};
            rate_code_reg    <= {arg_reg[4], arg_reg[3], arg_reg[2]};
            bit_cycles_reg   <= bit_cycles({arg_reg[4], arg_reg[3], arg_reg[2]});
        end
    end

    assign flash_addr   = addr_reg;
    assign program_time = program_time_reg;
    assign rate_code    = rate_code_reg;
endmodule

/* bench/host_uart.sv */
// host programmer model: 8n1 serial sender and receiver with rts/cts
// assumes one clk; the bench sets bit_cyc after a rate change and hold_cts to stall
`timescale 1ns/1ps
module host_uart (
    // clock
    input  wire logic clk,
    // device serial pins
    input  wire logic txd,
    input  wire logic rts_n,
    output logic      rxd,
    output logic      cts_n
);
    int         bit_cyc  = 868;
    logic       hold_cts = 1'b0;
    logic [7:0] rx_q[$];

    initial rxd = 1'b1;
    assign cts_n = hold_cts;

    // bounded wait on rts_n; a stuck device then shows as a missing reply
    task automatic send(input logic [7:0] b);
        int i;
        for (i = 0; i < 50000 && rts_n !== 1'b0; i++) @(posedge clk);
        for (i = 0; i < 10; i++) begin
            rxd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
            repeat (bit_cyc) @(posedge clk);
        end
    endtask

    // bad stop bit queues unknown so that the compare fails
    always begin : rx_proc
        logic [7:0] d;
        int         k;
        @(negedge txd);
        repeat (bit_cyc / 2) @(posedge clk);
        for (k = 0; k < 8; k++) begin
            repeat (bit_cyc) @(posedge clk);
            d[k] = txd;
        end
        repeat (bit_cyc) @(posedge clk);
        rx_q.push_back(txd ? d : 8'hXX);
    end
endmodule

/* bench/boot_loader_props.sv */
// concurrent checks on the loader ports
// assumes bind into boot_loader; one clock domain
`timescale 1ns/1ps
module boot_loader_props #(
    parameter int ADDR_W = 16
) (
    // clock and reset
    input wire logic              clk,
    input wire logic              reset_n,
    // mode strap
    input wire logic              program_select_n,
    input wire logic              loader_active,
    // serial link
    input wire logic              txd,
    input wire logic              rts_n,
    // flash port
    input wire logic              flash_rd,
    input wire logic              flash_wr,
    // settings
    input wire logic [15:0]       program_time,
    input wire logic [23:0]       rate_code
);
    logic [3:0] settle_reg;

    // mode capture finishes well inside 15 edges
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            settle_reg <= 4'h0;
        end else if (settle_reg != 4'hF) begin
            settle_reg <= settle_reg + 4'h1;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_rd_single_pulse: assert property (flash_rd |=> !flash_rd)
        else $error("flash read pulse longer than one cycle");
    a_wr_single_pulse: assert property (flash_wr |=> !flash_wr)
        else $error("flash write pulse longer than one cycle");
    a_no_rd_wr: assert property (!(flash_rd && flash_wr))
        else $error("flash read and write together");
    a_run_no_flash: assert property (!loader_active |-> !flash_rd && !flash_wr)
        else $error("flash access in run mode");
    a_run_tx_idle: assert property (!loader_active |-> txd)
        else $error("serial output active in run mode");
    a_time_run_hold: assert property (!loader_active |-> $stable(program_time))
        else $error("program time changed in run mode");
    a_rate_run_hold: assert property (!loader_active |-> $stable(rate_code))
        else $error("rate code changed in run mode");
    a_mode_stays_fixed: assert property (settle_reg == 4'hF |-> $stable(loader_active))
        else $error("mode changed after capture");
    a_loader_entry: assert property ($rose(reset_n) && !program_select_n
        |-> ##[1:8] loader_active)
        else $error("loader mode not entered");
    a_release_idle: assert property ($rose(reset_n) |-> txd && rts_n)
        else $error("serial lines not idle at reset release");
endmodule

bind boot_loader boot_loader_props #(.ADDR_W(ADDR_W)) u_props (
    .clk, .reset_n, .program_select_n, .loader_active, .txd, .rts_n,
    .flash_rd, .flash_wr, .program_time, .rate_code
);

/* bench/uart_flash_bootloader_protocol_tb.sv */
// self-checking bench for the loader: host model, flash model, reference
// assumes host_uart and boot_loader_props compiled before this file
`timescale 1ns/1ps
module uart_flash_bootloader_protocol_tb;
    import boot_pkg::*;
    logic        clk, reset_n, program_select_n, loader_active, rxd, txd, cts_n, rts_n;
    logic        flash_rd, flash_wr, flash_wr_done;
    logic [15:0] flash_addr, program_time;
    logic [7:0]  flash_rdata, flash_wdata;
    logic [23:0] rate_code;
    int          n_errors = 0;
    int          checked  = 0;
    int          seed     = 16521;
    int          wr_wait  = 0;
    logic [7:0]  written [logic [15:0]];
    logic [7:0]  fmem [logic [15:0]];
    logic [23:0] wr_q[$];

    boot_loader #(.ADDR_W(16)) dut (
        .clk, .reset_n, .program_select_n, .loader_active, .rxd, .txd, .cts_n,
        .rts_n, .flash_addr, .flash_rd, .flash_rdata, .flash_wr, .flash_wdata,
        .flash_wr_done, .program_time, .rate_code
    );
    host_uart host (.clk, .txd, .rts_n, .rxd, .cts_n);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic test_done();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [7:0] exp_mem(input logic [15:0] a);
        return written.exists(a) ? written[a] : (a[7:0] ^ 8'h5A);
    endfunction

    task automatic cmd(input logic [7:0] q[$]);
        foreach (q[i]) host.send(q[i]);
    endtask

    task automatic expect_byte(input logic [7:0] b);
        int i;
        for (i = 0; i < 30000 && host.rx_q.size() == 0; i++) @(posedge clk);
        if (host.rx_q.size() == 0) begin
            n_errors++;
            $display("[ERR] reply byte expected %h seen none", b);
            test_done();
        end else begin
            chk("reply byte", {24'h0, b}, {24'h0, host.rx_q.pop_front()});
        end
    endtask

    // flash: one-cycle read latency, write done after a random few cycles
    always @(posedge clk) begin
        if (flash_rd) flash_rdata <= fmem.exists(flash_addr) ? fmem[flash_addr]
                                                              : (flash_addr[7:0] ^ 8'h5A);
        flash_wr_done <= 1'b0;
        if (flash_wr) begin
            fmem[flash_addr] = flash_wdata;
            wr_wait <= 2 + ($random(seed) & 7);
            chk("flash write", {8'h0, wr_q.pop_front()}, {8'h0, flash_addr, flash_wdata});
        end else if (wr_wait > 0) begin
            wr_wait <= wr_wait - 1;
            flash_wr_done <= (wr_wait == 1);
        end
    end

    initial begin
        repeat (110000) @(posedge clk);
        n_errors++;
        $display("[ERR] run length expected finish seen timeout");
        test_done();
    end

    initial begin
        logic [15:0] a;
        logic [15:0] t;
        logic [7:0]  d;
        int          i;
        reset_n          = 1'b0;
        program_select_n = 1'b1;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        repeat (20) @(posedge clk);
        chk("run mode flag", 32'h0, {31'h0, loader_active});
        program_select_n <= 1'b0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        for (i = 0; i < 20 && loader_active !== 1'b1; i++) @(posedge clk);
        chk("loader flag", 32'h1, {31'h0, loader_active});
        chk("time reset", 32'h1770, {16'h0, program_time});
        chk("rate reset", 32'h1A, {8'h0, rate_code});
        // first command at the default rate; too slow to do more here
        cmd('{OP_SET_VARS, 8'h70, 8'h17, 8'h03, 8'h00, 8'h00});
        expect_byte(ACK_BYTE);
        // settings land only after the ack stop bit has left
        repeat (700) @(posedge clk);
        host.bit_cyc = 100;
        chk("rate code", 32'h3, {8'h0, rate_code});
        t = 16'($random(seed));
        cmd('{OP_SET_VARS, t[7:0], t[15:8], 8'h03, 8'h00, 8'h00});
        expect_byte(ACK_BYTE);
        repeat (100) @(posedge clk);
        chk("program time", {16'h0, t}, {16'h0, program_time});
        for (i = 0; i < 2; i++) begin
            d = i ? OP_ECHO_B : OP_ECHO_A;
            host.send(d);
            expect_byte(d);
        end
        host.hold_cts <= 1'b1;
        host.send(OP_ECHO_A);
        repeat (1200) @(posedge clk);
        chk("bytes under stall", 32'h0, 32'(host.rx_q.size()));
        host.hold_cts <= 1'b0;
        expect_byte(OP_ECHO_A);
        a = 16'($random(seed));
        // short blocks keep the run brief; a real host always sends 128
        cmd('{OP_WRITE, a[7:0], a[15:8], 8'h04});
        expect_byte(ACK_BYTE);
        for (i = 0; i < 4; i++) begin
            d = 8'($random(seed));
            written[a + 16'(i)] = d;
            wr_q.push_back({a + 16'(i), d});
            host.send(d);
        end
        expect_byte(ACK_BYTE);
        chk("writes left", 32'h0, 32'(wr_q.size()));
        cmd('{OP_READ, a[7:0], a[15:8], 8'h05});
        expect_byte(ACK_BYTE);
        for (i = 0; i < 5; i++) expect_byte(exp_mem(a + 16'(i)));
        cmd('{OP_READ, a[7:0], a[15:8], 8'h00});
        expect_byte(ACK_BYTE);
        // unknown opcode is dropped; the echo shows the next byte is an opcode
        host.send(8'h55);
        host.send(OP_ECHO_B);
        expect_byte(OP_ECHO_B);
        test_done();
    end
endmodule
